// File: vcozd_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - first setup after reset starts calibration once start bit is committed.
// - staged settings, start bit included, take effect only on update strobe.
// - calibration-done readback reads one after a calibration finishes.
// - calibration asserts sync, calibrates, then releases sync and closes loop in the same cycle.
// - outputs may resume before loop settles; no hold until lock.
// - calibration clock is phase detector rate over selected calibration divider.
// - calibration lasts a fixed count of calibration clocks, then done.
// - never calibrate automatically on divider or reference change.
// - internal zero delay routes channel divider zero to feedback divider.
// - external zero delay takes feedback from clock input pins.
// - two-bit channel field is committed but unused; internal zero delay feedback always comes from channel divider zero.
// - channel dividers held synchronised so outputs align to reference.
// - programmable delays in reference and feedback paths.
// - auto-load at power-up loads settings then calibrates if reference valid.
module vcozd_ctrl
   import vcozd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // staged setup bits
   input wire logic cal_start,
   input wire logic [1:0] cal_div_sel,
   input wire logic [1:0] zd_mode,
   input wire logic [1:0] zd_chan_sel,
   input wire logic [vcozd_pkg::DLY_W-1:0] ref_delay_set,
   input wire logic [vcozd_pkg::DLY_W-1:0] fb_delay_set,
   input wire logic update_regs,
   // power-up auto load
   input wire logic autoload_done,
   input wire logic ref_valid,
   // phase detector rate pulse, one sys_clk wide
   input wire logic pfd_tick,
   // feedback sources
   input wire logic [vcozd_pkg::NUM_CHAN-1:0] chan_div_out,
   input wire logic ext_clk_in,
   input wire logic vco_fb_in,
   // status and control outputs
   output logic cal_done,
   output logic cal_busy,
   output logic out_sync,
   output logic loop_closed,
   output logic fb_to_ndiv,
   output logic fb_select_mux_a,
   output logic fb_select_mux_b,
   output logic [vcozd_pkg::DLY_W-1:0] ref_delay,
   output logic [vcozd_pkg::DLY_W-1:0] fb_delay
);
   import vcozd_pkg::*;

   logic act_start;
   logic [1:0] act_div;
   logic [1:0] act_zd;
   logic [1:0] act_chan;
   logic start_prev;
   logic cal_req;
   vcozd_state_t state;
   logic [CAL_DIV_W-1:0] div_cnt;
   logic [CAL_DIV_W-1:0] div_max;
   logic cal_tick;
   logic [CAL_LEN_W-1:0] cal_cnt;
   logic auto_armed;
   logic fb_src;

   // staged settings committed only by the update strobe
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         act_start <= 1'b0;
         act_div <= CAL_DIV_2;
         act_zd <= 2'h0;
         act_chan <= 2'h0;
         ref_delay <= '0;
         fb_delay <= '0;
      end else if (update_regs) begin
         act_start <= cal_start;
         act_div <= cal_div_sel;
         act_zd <= zd_mode;
         act_chan <= zd_chan_sel;
         ref_delay <= ref_delay_set;
         fb_delay <= fb_delay_set;
      end
   end

   // rising edge of committed start only; divider changes never start it
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         start_prev <= 1'b0;
         auto_armed <= 1'b1;
      end else begin
         start_prev <= act_start;
         if (autoload_done) begin
            auto_armed <= 1'b0;
         end
      end
   end

   // auto calibration fires once after load, and only with a reference
   assign cal_req = (act_start && !start_prev)
      || (auto_armed && autoload_done && ref_valid);

   always_comb begin
      case (act_div)
         CAL_DIV_2: div_max = CAL_DIV_CNT_2;
         CAL_DIV_4: div_max = CAL_DIV_CNT_4;
         CAL_DIV_8: div_max = CAL_DIV_CNT_8;
         default: div_max = CAL_DIV_CNT_16;
      endcase
   end

   // calibration clock as an enable derived from the pfd rate
   always_ff @(posedge sys_clk) begin
      if (sys_rst || state != VCOZD_CAL) begin
         div_cnt <= '0;
      end else if (pfd_tick) begin
         div_cnt <= (div_cnt == div_max) ? '0 : div_cnt + 1'b1;
      end
   end
   assign cal_tick = pfd_tick && (div_cnt == div_max);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= VCOZD_IDLE;
         cal_cnt <= '0;
      end else begin
         case (state)
            VCOZD_IDLE: begin
               if (cal_req) begin
                  state <= VCOZD_SYNC;
               end
            end
            VCOZD_SYNC: begin
               cal_cnt <= '0;
               state <= VCOZD_CAL;
            end
            VCOZD_CAL: begin
               if (cal_tick) begin
                  if (cal_cnt == CAL_CYCLES - 1'b1) begin
                     state <= VCOZD_DONE;
                  end else begin
                     cal_cnt <= cal_cnt + 1'b1;
                  end
               end
            end
            VCOZD_DONE: begin
               if (cal_req) begin
                  state <= VCOZD_SYNC;
               end
            end
            default: state <= VCOZD_IDLE;
         endcase
      end
   end

   // done stays set until a new calibration starts
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cal_done <= 1'b0;
      end else begin
         cal_done <= (state == VCOZD_DONE) && !cal_req;
      end
   end

   // sync released right at the end; no wait for lock
   assign cal_busy = (state == VCOZD_SYNC) || (state == VCOZD_CAL);
   assign out_sync = cal_busy;
   assign loop_closed = !cal_busy;

   // feedback routing
   assign fb_select_mux_b = (act_zd == ZD_EXTERNAL);
   assign fb_select_mux_a = (act_zd == ZD_INTERNAL) || (act_zd == ZD_EXTERNAL);
   always_comb begin
      case (act_zd)
         ZD_INTERNAL: fb_src = chan_div_out[0];
         ZD_EXTERNAL: fb_src = ext_clk_in;
         default: fb_src = vco_fb_in;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         fb_to_ndiv <= 1'b0;
      end else begin
         fb_to_ndiv <= fb_src;
      end
   end

   logic [CAL_LEN_W-1:0] tick_seen;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || state != VCOZD_CAL) begin
         tick_seen <= '0;
      end else if (cal_tick) begin
         tick_seen <= tick_seen + 1'b1;
      end
   end

   sequence s_cal_begin;
      (state == VCOZD_IDLE || state == VCOZD_DONE) && cal_req;
   endsequence
   sequence s_synced;
      out_sync && !loop_closed;
   endsequence

   a_start_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_cal_begin |=> s_synced [*2]) else $error("sync not asserted on start");
   a_done_after_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(cal_done) |-> $past(tick_seen) == CAL_CYCLES)
      else $error("calibration length wrong");
   a_done_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state == VCOZD_CAL && cal_tick && cal_cnt == CAL_CYCLES - 1'b1) |-> ##2 cal_done)
      else $error("done not raised");
   a_release_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(out_sync) |-> loop_closed && state == VCOZD_DONE)
      else $error("sync release wrong");
   a_no_auto_cal: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state == VCOZD_IDLE && !act_start && !autoload_done) |=> state != VCOZD_SYNC)
      else $error("spontaneous calibration");
   a_update_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !$past(update_regs) |-> $stable(act_start) && $stable(act_zd))
      else $error("setting changed without update");
   a_div_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
      act_div == CAL_DIV_4 |-> div_max == CAL_DIV_CNT_4) else $error("divider decode");
   a_int_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
      act_zd == ZD_INTERNAL |=> fb_to_ndiv == $past(chan_div_out[0]))
      else $error("internal feedback route");
   a_ext_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
      act_zd == ZD_EXTERNAL |=> fb_to_ndiv == $past(ext_clk_in))
      else $error("external feedback route");

   // end of a calibration: last tick of the fixed count
   sequence s_cal_end;
      state == VCOZD_CAL && cal_tick && cal_cnt == CAL_CYCLES - 1'b1;
   endsequence

   // sequencing of one calibration
   a_end_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_cal_end |=> !out_sync && loop_closed) else $error("sync not released at end");
   a_sync_one_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state == VCOZD_SYNC |=> state == VCOZD_CAL && cal_cnt == '0) else $error("sync step");
   a_loop_open: assert property (@(posedge sys_clk) disable iff (sys_rst)
      out_sync |-> !loop_closed) else $error("loop closed while outputs held");
   a_cal_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state == VCOZD_CAL && !cal_tick) |=> $stable(cal_cnt) && state == VCOZD_CAL)
      else $error("count moved without tick");

   // readback stays until the next request, then drops
   a_done_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (cal_done && !cal_req) |=> cal_done) else $error("done dropped early");
   a_done_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (cal_done && cal_req) |=> !cal_done) else $error("done not cleared on request");

   // every divider code, not just one
   a_div2_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
      act_div == CAL_DIV_2 |-> div_max == CAL_DIV_CNT_2) else $error("divider decode 2");
   a_div8_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
      act_div == CAL_DIV_8 |-> div_max == CAL_DIV_CNT_8) else $error("divider decode 8");
   a_div16_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
      act_div == CAL_DIV_16 |-> div_max == CAL_DIV_CNT_16) else $error("divider decode 16");

   // committed state only moves on the strobe
   a_chan_commit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !$past(update_regs) |-> $stable(act_chan) && $stable(act_div))
      else $error("channel or divider changed without update");
   a_delay_commit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !$past(update_regs) |-> $stable(ref_delay) && $stable(fb_delay))
      else $error("delay changed without update");

   // non zero delay modes keep the normal feedback
   a_normal_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (act_zd != ZD_INTERNAL && act_zd != ZD_EXTERNAL) |=> fb_to_ndiv == $past(vco_fb_in))
      else $error("normal feedback route");

   // after the auto load only a fresh committed start may begin a run
   a_auto_once: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!auto_armed && !(act_start && !start_prev)) |-> !cal_req)
      else $error("calibration without request");
endmodule // vcozd_ctrl
`default_nettype wire

// File: vcozd_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module vcozd_ctrl_test;
   import vcozd_pkg::*;
   logic sys_clk, sys_rst, cal_start, update_regs, autoload_done, ref_valid, pfd_tick;
   logic ext_clk_in, vco_fb_in, cal_done, cal_busy, out_sync, loop_closed;
   logic fb_to_ndiv, fb_select_mux_a, fb_select_mux_b;
   logic [1:0] cal_div_sel, zd_mode, zd_chan_sel;
   logic [DLY_W-1:0] ref_delay_set, fb_delay_set, ref_delay, fb_delay;
   logic [NUM_CHAN-1:0] chan_div_out;
   logic [3:0] status;
   int fails, tests_run, n, i;
   assign status = {cal_done, cal_busy, out_sync, loop_closed};
   vcozd_ctrl u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cal_start(cal_start),
      .cal_div_sel(cal_div_sel), .zd_mode(zd_mode), .zd_chan_sel(zd_chan_sel),
      .ref_delay_set(ref_delay_set), .fb_delay_set(fb_delay_set), .update_regs(update_regs),
      .autoload_done(autoload_done), .ref_valid(ref_valid), .pfd_tick(pfd_tick),
      .chan_div_out(chan_div_out), .ext_clk_in(ext_clk_in), .vco_fb_in(vco_fb_in),
      .cal_done(cal_done), .cal_busy(cal_busy), .out_sync(out_sync),
      .loop_closed(loop_closed), .fb_to_ndiv(fb_to_ndiv), .fb_select_mux_a(fb_select_mux_a),
      .fb_select_mux_b(fb_select_mux_b), .ref_delay(ref_delay), .fb_delay(fb_delay));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle commit, then a gap so the strobe is never re-raised at once
   task automatic commit(input logic start);
      cal_start = start;
      update_regs = 1'b1;
      step(1);
      update_regs = 1'b0;
      step(1);
   endtask
   task automatic tally_and_finish;
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // three calibrations of 4400 ticks at /2, /4, /8 plus a cut /16 take about 65000 cycles
   initial begin
      #800000;
      fails++;
      tally_and_finish();
   end
   initial begin
      fails = 0;
      tests_run = 0;
      sys_rst = 1'b1;
      {cal_start, update_regs, autoload_done, ref_valid, pfd_tick} = 5'h0;
      {ext_clk_in, vco_fb_in, cal_div_sel, zd_mode, zd_chan_sel} = 8'h0;
      {ref_delay_set, fb_delay_set, chan_div_out} = 12'h0;
      step(10);
      sys_rst = 1'b0;
      chk(status, 4'h1);
      // staged values must not leak before the commit strobe
      zd_mode = ZD_INTERNAL;
      ref_delay_set = 4'h5;
      fb_delay_set = 4'ha;
      chan_div_out = 4'h1; // only divider zero driven high, the others low
      step(2);
      chk({fb_select_mux_a, fb_select_mux_b, 2'h0}, 4'h0);
      chk(ref_delay | fb_delay, 4'h0);
      commit(1'b0);
      chk({fb_select_mux_a, fb_select_mux_b, fb_to_ndiv, 1'b0}, 4'ha);
      chk(ref_delay, 4'h5);
      chk(fb_delay, 4'ha);
      chan_div_out = 4'he;
      step(2);
      chk({3'h0, fb_to_ndiv}, 4'h0);
      zd_mode = ZD_EXTERNAL;
      zd_chan_sel = 2'h2;
      ext_clk_in = 1'b1;
      commit(1'b0);
      chk({fb_select_mux_a, fb_select_mux_b, fb_to_ndiv, 1'b0}, 4'he);
      ext_clk_in = 1'b0;
      zd_mode = 2'h0;
      vco_fb_in = 1'b1;
      commit(1'b0);
      chk({fb_select_mux_a, fb_select_mux_b, fb_to_ndiv, 1'b0}, 4'h2);
      chk(status, 4'h1);
      // loop settings taken as programmed; reference present from here
      pfd_tick = 1'b1;
      for (i = 0; i < 3; i++) begin
         cal_div_sel = i[1:0]; // divider change, then a fresh request
         if (i > 0) begin
            // start already high: committing it again is no new request
            commit(1'b1);
            step(2);
            chk(status, 4'h9);
         end
         commit(1'b0);
         commit(1'b1);
         step(1);
         chk(status, 4'h6);
         step(4400 * (2 << i) - 20);
         chk(status, 4'h6);
         n = 0;
         while (cal_done !== 1'b1 && n < 60) begin
            step(1);
            n++;
         end
         chk(status, 4'h9);
         chk({3'h0, n >= 20 - (2 << i) && n <= 24}, 4'h1);
      end
      // divide by 16 in full is too long: check the hold, then cut it by a reset
      cal_div_sel = CAL_DIV_16;
      commit(1'b0);
      commit(1'b1);
      step(1);
      chk(status, 4'h6);
      step(2000);
      chk(status, 4'h6);
      sys_rst = 1'b1;
      step(2);
      sys_rst = 1'b0;
      chk(status, 4'h1);
      ref_valid = 1'b1;
      autoload_done = 1'b1;
      step(1);
      autoload_done = 1'b0;
      step(3);
      chk({3'h0, cal_busy}, 4'h1);
      tally_and_finish();
   end
endmodule // vcozd_ctrl_test
`default_nettype wire

// File: vcozd_pkg.sv
package vcozd_pkg;
   // calibration divider codes
   localparam logic [1:0] CAL_DIV_2 = 2'h0;
   localparam logic [1:0] CAL_DIV_4 = 2'h1;
   localparam logic [1:0] CAL_DIV_8 = 2'h2;
   localparam logic [1:0] CAL_DIV_16 = 2'h3;
   localparam int CAL_DIV_W = 4;
   localparam logic [CAL_DIV_W-1:0] CAL_DIV_CNT_2 = 4'h1;
   localparam logic [CAL_DIV_W-1:0] CAL_DIV_CNT_4 = 4'h3;
   localparam logic [CAL_DIV_W-1:0] CAL_DIV_CNT_8 = 4'h7;
   localparam logic [CAL_DIV_W-1:0] CAL_DIV_CNT_16 = 4'hf;
   // calibration length in calibration clock cycles
   localparam int CAL_LEN_W = 13;
   localparam logic [CAL_LEN_W-1:0] CAL_CYCLES = 13'h1130;
   // zero delay mode field
   localparam logic [1:0] ZD_INTERNAL = 2'h1;
   localparam logic [1:0] ZD_EXTERNAL = 2'h3;
   localparam int NUM_CHAN = 4;
   localparam int DLY_W = 4;
   typedef enum logic [1:0] {
      VCOZD_IDLE,
      VCOZD_SYNC,
      VCOZD_CAL,
      VCOZD_DONE
   } vcozd_state_t;
endpackage
